// ---- hw/period_match_timer8.sv ----
// Module: 8-bit period match timer with prescaler, postscaler and Avalon-MM register slave
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`timescale 1ns/1ns
module period_match_timer8 (
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        SYS_RST,
  // Avalon-MM slave
  input  wire logic [4:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // Timer outputs
  output logic             MATCH_OUT,
  output logic             SHIFT_CLK_OUT,
  output logic             IRQ_OUT
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  period_match_timer8_pkg::timer_control_t ctrl_ff;
  period_match_timer8_pkg::avalon_req_t    req;
  logic [7:0]  count_ff;
  logic [7:0]  period_ff;
  logic [5:0]  pre_cnt_ff;
  logic [3:0]  post_cnt_ff;
  logic        flag_ff;
  logic        enable_ff;
  logic        waitreq_ff;
  logic [31:0] rdata_ff;
  logic        match_ff;
  logic        shift_clk_ff;
  logic        irq_ff;

  logic        accept;
  logic        wr_lane0;
  logic        wr_count;
  logic        wr_period;
  logic        wr_control;
  logic        wr_flag;
  logic        wr_enable;
  logic        rd_flag;
  logic [5:0]  pre_last;
  logic        tick;
  logic        match_now;
  logic        post_done;
  logic [31:0] nxt_rdata;

  assign req = '{read: AVS_READ, write: AVS_WRITE, address: AVS_ADDRESS,
                 writedata: AVS_WRITEDATA, byteenable: AVS_BYTEENABLE};

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  // Transfer completes in the cycle waitrequest is low
  assign accept     = !waitreq_ff && (req.read || req.write);
  assign wr_lane0   = accept && req.write && req.byteenable[0];
  assign wr_count   = wr_lane0 && req.address == period_match_timer8_pkg::ADDR_COUNT;
  assign wr_period  = wr_lane0 && req.address == period_match_timer8_pkg::ADDR_PERIOD;
  assign wr_control = wr_lane0 && req.address == period_match_timer8_pkg::ADDR_CONTROL;
  assign wr_flag    = wr_lane0 && req.address == period_match_timer8_pkg::ADDR_FLAG;
  assign wr_enable  = wr_lane0 && req.address == period_match_timer8_pkg::ADDR_ENABLE;
  assign rd_flag    = accept && req.read && req.address == period_match_timer8_pkg::ADDR_FLAG;

  // One wait cycle, then one ready cycle
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      waitreq_ff <= 1'b1;
    end else begin
      waitreq_ff <= !(waitreq_ff && (req.read || req.write));
    end
  end

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (req.address)
      period_match_timer8_pkg::ADDR_COUNT:   nxt_rdata[7:0] = count_ff;
      period_match_timer8_pkg::ADDR_PERIOD:  nxt_rdata[7:0] = period_ff;
      period_match_timer8_pkg::ADDR_CONTROL: nxt_rdata[6:0] = ctrl_ff[6:0];
      period_match_timer8_pkg::ADDR_FLAG: begin
        nxt_rdata[period_match_timer8_pkg::MATCH_BIT] = flag_ff;
      end
      period_match_timer8_pkg::ADDR_ENABLE: begin
        nxt_rdata[period_match_timer8_pkg::MATCH_BIT] = enable_ff;
      end
      default:                               nxt_rdata = 32'h0000_0000;
    endcase
  end

  // Read data is sampled in the wait cycle and held through the ready cycle
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      rdata_ff <= 32'h0000_0000;
    end else if (waitreq_ff && req.read) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      ctrl_ff <= period_match_timer8_pkg::CONTROL_RESET;
    end else if (wr_control) begin
      ctrl_ff        <= req.writedata[7:0];
      ctrl_ff.unused <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      period_ff <= period_match_timer8_pkg::PERIOD_RESET;
    end else if (wr_period) begin
      period_ff <= req.writedata[7:0];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      enable_ff <= 1'b0;
    end else if (wr_enable) begin
      enable_ff <= req.writedata[period_match_timer8_pkg::MATCH_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Prescaler
  // ---------------------------------------------------------------
  always_comb begin
    case (ctrl_ff.prescale_select)
      period_match_timer8_pkg::PRESCALE_1: pre_last = period_match_timer8_pkg::PRE_LAST_DIV1;
      period_match_timer8_pkg::PRESCALE_4: pre_last = period_match_timer8_pkg::PRE_LAST_DIV4;
      default:                             pre_last = period_match_timer8_pkg::PRE_LAST_DIV16;
    endcase
  end

  // No step in a control write cycle, so the count keeps its value
  assign tick = ctrl_ff.timer_on && pre_cnt_ff == pre_last
                && !wr_control && !wr_count;

  // A restart always passes a control write, so the first step is a full period late

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST || wr_count || wr_control) begin
      pre_cnt_ff <= period_match_timer8_pkg::PRE_RESET;
    end else if (!ctrl_ff.timer_on) begin
      pre_cnt_ff <= pre_cnt_ff;
    end else if (pre_cnt_ff >= pre_last) begin
      pre_cnt_ff <= period_match_timer8_pkg::PRE_RESET;
    end else begin
      pre_cnt_ff <= pre_cnt_ff + 6'h01;
    end
  end

  // ---------------------------------------------------------------
  // Count and match
  // ---------------------------------------------------------------
  assign match_now = tick && count_ff == period_ff;

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      count_ff <= period_match_timer8_pkg::COUNT_RESET;
    end else if (wr_count) begin
      count_ff <= req.writedata[7:0];
    end else if (match_now) begin
      count_ff <= period_match_timer8_pkg::COUNT_RESET;
    end else if (tick) begin
      count_ff <= count_ff + 8'h01;
    end
  end

  // Unscaled match feeds PWM units; halved copy serves as serial shift clock
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      match_ff     <= 1'b0;
      shift_clk_ff <= 1'b0;
    end else begin
      match_ff     <= match_now;
      shift_clk_ff <= shift_clk_ff ^ match_now;
    end
  end

  // ---------------------------------------------------------------
  // Postscaler and interrupt
  // ---------------------------------------------------------------
  // Terminal value equals the select code, so code 0 flags every match
  assign post_done = match_now && post_cnt_ff == ctrl_ff.postscale_select;

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST || wr_count || wr_control) begin
      post_cnt_ff <= period_match_timer8_pkg::POST_RESET;
    end else if (post_done) begin
      post_cnt_ff <= period_match_timer8_pkg::POST_RESET;
    end else if (match_now) begin
      post_cnt_ff <= post_cnt_ff + 4'h1;
    end
  end

  // Read clears only what the read reported; a new event always wins
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      flag_ff <= 1'b0;
    end else if (post_done) begin
      flag_ff <= 1'b1;
    end else if (rd_flag && rdata_ff[period_match_timer8_pkg::MATCH_BIT]) begin
      flag_ff <= 1'b0;
    end else if (wr_flag && !req.writedata[period_match_timer8_pkg::MATCH_BIT]) begin
      flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= flag_ff && enable_ff;
    end
  end

  assign AVS_READDATA    = rdata_ff;
  assign AVS_WAITREQUEST = waitreq_ff;
  assign MATCH_OUT       = match_ff;
  assign SHIFT_CLK_OUT   = shift_clk_ff;
  assign IRQ_OUT         = irq_ff;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);

  sequence s_wrap_step;
    tick && count_ff == period_ff && !wr_count;
  endsequence

  sequence s_cleared_after;
    count_ff == 8'h00 && MATCH_OUT;
  endsequence

  a_match_wraps_count: assert property (s_wrap_step |=> s_cleared_after)
    else $error("match did not zero the count");

  a_count_steps_one: assert property (tick && count_ff != period_ff
                                      |=> count_ff == $past(count_ff) + 8'h01)
    else $error("count did not step by one");

  a_reset_values: assert property ($fell(SYS_RST) |-> count_ff == 8'h00 && period_ff == 8'hFF
                                   && pre_cnt_ff == 6'h00 && post_cnt_ff == 4'h0)
    else $error("wrong values after reset");

  a_scaler_clear: assert property (wr_count || wr_control
                                   |=> pre_cnt_ff == 6'h00 && post_cnt_ff == 4'h0)
    else $error("scalers not cleared by write");

  a_ctrl_keeps_count: assert property (wr_control |=> $stable(count_ff))
    else $error("control write changed the count");

  a_off_holds_all: assert property (!ctrl_ff.timer_on && !wr_count && !wr_control
                                    |=> $stable(count_ff) && $stable(pre_cnt_ff)
                                    && !MATCH_OUT)
    else $error("counters moved while timer off");

  // Divide by one needs three quiet cycles after a wrap to reach its last value
  sequence s_div1_start;
    ctrl_ff.timer_on && ctrl_ff.prescale_select == period_match_timer8_pkg::PRESCALE_1
    && pre_cnt_ff == 6'h00 && !wr_count && !wr_control;
  endsequence

  a_div1_rate: assert property (s_div1_start ##1 (!wr_count && !wr_control) [*2]
                                |=> pre_cnt_ff == period_match_timer8_pkg::PRE_LAST_DIV1)
    else $error("divide by one tick spacing wrong");

  a_prescale_bound: assert property (pre_cnt_ff <= pre_last)
    else $error("prescaler passed its last value");

  a_post_steps: assert property (match_now && !post_done
                                 |=> post_cnt_ff == $past(post_cnt_ff) + 4'h1)
    else $error("postscaler did not count the match");

  a_flag_on_terminal: assert property (post_done |=> flag_ff && post_cnt_ff == 4'h0)
    else $error("terminal count did not set flag");

  a_flag_sticky: assert property (flag_ff && !rd_flag && !wr_flag |=> flag_ff)
    else $error("flag dropped without software clear");

  a_match_pulse: assert property (MATCH_OUT |=> !MATCH_OUT)
    else $error("match output longer than one cycle");

  a_shift_toggles: assert property (match_now
                                    |=> SHIFT_CLK_OUT != $past(SHIFT_CLK_OUT))
    else $error("shift clock did not toggle on match");

  a_shift_holds: assert property (!match_now |=> $stable(SHIFT_CLK_OUT))
    else $error("shift clock moved without match");

  // Registered output, so the interrupt trails the flag by one cycle
  a_irq_gated: assert property (flag_ff && enable_ff |=> IRQ_OUT)
    else $error("enabled flag did not raise interrupt");

  a_irq_masked: assert property (!(flag_ff && enable_ff) |=> !IRQ_OUT)
    else $error("interrupt raised without enabled flag");

  // ---------------------------------------------------------------
  // Control bit 7 and bus handshake checks
  // ---------------------------------------------------------------
  a_bit7_reads_zero: assert property (!waitreq_ff && req.read
                                      && req.address == period_match_timer8_pkg::ADDR_CONTROL
                                      |-> !AVS_READDATA[7])
    else $error("control bit 7 read as one");

  a_bit7_stored: assert property (wr_control |=> !ctrl_ff.unused)
    else $error("control bit 7 stored a one");

  a_one_wait_cycle: assert property ((req.read || req.write) && waitreq_ff |=> !waitreq_ff)
    else $error("slave did not answer after one wait");

  a_idle_waits: assert property (waitreq_ff && !req.read && !req.write |=> waitreq_ff)
    else $error("waitrequest dropped without a request");

  // Software may take the data late; it stands until the next read
  a_rdata_stands: assert property (!(waitreq_ff && req.read) |=> $stable(AVS_READDATA))
    else $error("read data changed between reads");

endmodule : period_match_timer8

// ---- hw/period_match_timer8_pkg.sv ----
// Package: register map, field layout, reset values and timing counts of the period timer
package period_match_timer8_pkg;

  // ---------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------
  localparam logic [4:0] ADDR_COUNT   = 5'h00;
  localparam logic [4:0] ADDR_PERIOD  = 5'h04;
  localparam logic [4:0] ADDR_CONTROL = 5'h08;
  localparam logic [4:0] ADDR_FLAG    = 5'h0C;
  localparam logic [4:0] ADDR_ENABLE  = 5'h10;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int         MATCH_BIT      = 1;
  localparam logic [7:0] COUNT_RESET    = 8'h00;
  localparam logic [7:0] PERIOD_RESET   = 8'hFF;
  localparam logic [7:0] CONTROL_RESET  = 8'h00;
  localparam logic [3:0] POST_RESET     = 4'h0;
  localparam logic [5:0] PRE_RESET      = 6'h00;

  // ---------------------------------------------------------------
  // Timing: last prescaler value per prescaled count step (system clock ticks minus one)
  // ---------------------------------------------------------------
  localparam int         CLK_PERIOD_NS  = 10;
  localparam int         INSTR_DIV      = 4;
  localparam logic [5:0] PRE_LAST_DIV1  = 6'(INSTR_DIV * 1 - 1);
  localparam logic [5:0] PRE_LAST_DIV4  = 6'(INSTR_DIV * 4 - 1);
  localparam logic [5:0] PRE_LAST_DIV16 = 6'(INSTR_DIV * 16 - 1);

  // Prescale codes
  localparam logic [1:0] PRESCALE_1     = 2'h0;
  localparam logic [1:0] PRESCALE_4     = 2'h1;

  // ---------------------------------------------------------------
  // Control register layout
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       unused;
    logic [3:0] postscale_select;
    logic       timer_on;
    logic [1:0] prescale_select;
  } timer_control_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } avalon_req_t;

endpackage : period_match_timer8_pkg

// ---- verification/period_match_timer8_tb.sv ----
// Self-checking testbench for the period match timer
`timescale 1ns/1ns
module period_match_timer8_tb;
  logic        clk_sys;
  logic        sys_rst;
  logic [4:0]  address;
  logic        read;
  logic        write;
  logic [31:0] wdata;
  logic [3:0]  be;
  logic [31:0] rdata;
  logic        waitreq;
  logic        match_out;
  logic        shift_clk;
  logic        irq;
  logic        shift_prev;
  logic [7:0]  v;
  logic [7:0]  p;
  logic [31:0] rq;
  int          n_errors;
  int          n_checks;
  int          seed;
  int          cyc;
  int          n_match;
  int          n_tog;
  int          last_m;
  int          prev_m;
  int          m0;
  int          t;

  period_match_timer8 dut (
    .CLK_SYS         (clk_sys),
    .SYS_RST         (sys_rst),
    .AVS_ADDRESS     (address),
    .AVS_READ        (read),
    .AVS_WRITE       (write),
    .AVS_WRITEDATA   (wdata),
    .AVS_BYTEENABLE  (be),
    .AVS_READDATA    (rdata),
    .AVS_WAITREQUEST (waitreq),
    .MATCH_OUT       (match_out),
    .SHIFT_CLK_OUT   (shift_clk),
    .IRQ_OUT         (irq)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ---------------------------------------------------------------
  // Output monitor
  // ---------------------------------------------------------------
  always @(posedge clk_sys) begin
    cyc        <= cyc + 1;
    shift_prev <= shift_clk;
    if (!sys_rst && match_out === 1'b1) begin
      n_match <= n_match + 1;
      prev_m  <= last_m;
      last_m  <= cyc;
    end
    if (!sys_rst && shift_clk !== shift_prev) n_tog <= n_tog + 1;
  end

  task automatic end_sim;
    if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim

  task automatic check_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : check_reg

  task automatic check_cnt(input string nm, input int e, input int g);
    n_checks++;
    if (g != e) begin
      n_errors++;
      $display("wrong value %s expected %0d seen %0d", nm, e, g);
    end
  endtask : check_cnt

  // Holds the request until waitrequest is sampled low, then idles one edge
  task automatic bus(input logic rd, input logic [4:0] a, input logic [7:0] d,
                     input logic [3:0] b, output logic [31:0] q);
    int n;
    n = 0;
    address <= a;
    wdata   <= {24'h00_0000, d};
    be      <= b;
    read    <= rd;
    write   <= !rd;
    @(posedge clk_sys);
    while (waitreq !== 1'b0 && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 50) n_errors++;
    q = rdata;
    read  <= 1'b0;
    write <= 1'b0;
    @(posedge clk_sys);
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b0, a, d, 4'hF, q);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [4:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b1, a, 8'h00, 4'h0, q);
    check_reg(nm, {24'h00_0000, e}, q);
  endtask : rd_chk

  task automatic wait_matches(input int k);
    int n;
    n = 0;
    m0 = n_match + k;
    while (n_match < m0 && n < 5000) begin
      @(posedge clk_sys);
      n++;
    end
  endtask : wait_matches

  function automatic int exp_interval(input logic [1:0] code, input logic [7:0] per);
    return period_match_timer8_pkg::INSTR_DIV * (code == 2'h0 ? 1 : code == 2'h1 ? 4 : 16)
           * (int'(per) + 1);
  endfunction : exp_interval

  function automatic logic [7:0] ctl(input logic [3:0] post, input logic on,
                                     input logic [1:0] pre);
    return {1'b0, post, on, pre};
  endfunction : ctl

  initial begin
    {n_errors, n_checks, cyc, n_match, n_tog, last_m, prev_m} = '0;
    seed = 37;
    {address, read, write, wdata, be, shift_prev} = '0;
    sys_rst = 1'b1;
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    rd_chk("count", period_match_timer8_pkg::ADDR_COUNT, 8'h00);
    rd_chk("period", period_match_timer8_pkg::ADDR_PERIOD, 8'hFF);
    rd_chk("control", period_match_timer8_pkg::ADDR_CONTROL, 8'h00);
    rd_chk("flag", period_match_timer8_pkg::ADDR_FLAG, 8'h00);
    rd_chk("unmapped", 5'h14, 8'h00);
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      wr(period_match_timer8_pkg::ADDR_PERIOD, v);
      rd_chk("period rw", period_match_timer8_pkg::ADDR_PERIOD, v);
      wr(period_match_timer8_pkg::ADDR_COUNT, ~v);
      rd_chk("count rw", period_match_timer8_pkg::ADDR_COUNT, ~v);
    end
    bus(1'b0, period_match_timer8_pkg::ADDR_PERIOD, ~v, 4'h0, rq);
    rd_chk("period lane off", period_match_timer8_pkg::ADDR_PERIOD, v);
    wr(period_match_timer8_pkg::ADDR_CONTROL, 8'hFB);
    rd_chk("control bit7", period_match_timer8_pkg::ADDR_CONTROL, 8'h7B);
    rd_chk("count kept", period_match_timer8_pkg::ADDR_COUNT, ~v);
    p = ~v;
    // Stop mid-run: count and match output must freeze
    wr(period_match_timer8_pkg::ADDR_PERIOD, 8'hFF);
    wr(period_match_timer8_pkg::ADDR_CONTROL, ctl(4'h0, 1'b1, 2'h0));
    repeat (100) @(posedge clk_sys);
    wr(period_match_timer8_pkg::ADDR_CONTROL, 8'h00);
    bus(1'b1, period_match_timer8_pkg::ADDR_COUNT, 8'h00, 4'h0, rq);
    v = rq[7:0];
    check_cnt("count moved", 1, int'(v != p));
    m0 = n_match;
    repeat (200) @(posedge clk_sys);
    rd_chk("count held", period_match_timer8_pkg::ADDR_COUNT, v);
    check_cnt("match while off", m0, n_match);
    for (int code = 0; code < 4; code++) begin
      p = (code == 0) ? 8'h00 : 8'($random(seed) & 7);
      wr(period_match_timer8_pkg::ADDR_PERIOD, p);
      wr(period_match_timer8_pkg::ADDR_COUNT, 8'h00);
      wr(period_match_timer8_pkg::ADDR_CONTROL, ctl(4'h0, 1'b1, 2'(code)));
      wait_matches(3);
      check_cnt("match interval", exp_interval(2'(code), p), last_m - prev_m);
    end
    wr(period_match_timer8_pkg::ADDR_CONTROL, 8'h00);
    repeat (5) @(posedge clk_sys);
    check_cnt("shift toggles", n_match, n_tog);
    rd_chk("flag from runs", period_match_timer8_pkg::ADDR_FLAG, 8'h02);
    wr(period_match_timer8_pkg::ADDR_ENABLE, 8'h02);
    for (int k = 0; k < 3; k++) begin
      v = (k == 0) ? 8'h00 : (k == 1) ? 8'h0F : 8'($random(seed) & 15);
      rd_chk("flag idle", period_match_timer8_pkg::ADDR_FLAG, 8'h00);
      wr(period_match_timer8_pkg::ADDR_PERIOD, 8'($random(seed) & 3));
      wr(period_match_timer8_pkg::ADDR_COUNT, 8'h00);
      t = n_match;
      wr(period_match_timer8_pkg::ADDR_CONTROL, ctl(v[3:0], 1'b1, 2'h0));
      for (int n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge clk_sys);
      check_cnt("matches to flag", int'(v) + 1, n_match - t);
      wr(period_match_timer8_pkg::ADDR_CONTROL, 8'h00);
      repeat (20) @(posedge clk_sys);
      check_reg("irq level", 32'h0000_0001, {31'h0000_0000, irq});
      rd_chk("flag set", period_match_timer8_pkg::ADDR_FLAG, 8'h02);
    end
    // Masked: flag sets but the interrupt line stays low
    wr(period_match_timer8_pkg::ADDR_ENABLE, 8'h00);
    wr(period_match_timer8_pkg::ADDR_CONTROL, ctl(4'h0, 1'b1, 2'h0));
    wait_matches(2);
    wr(period_match_timer8_pkg::ADDR_CONTROL, 8'h00);
    check_reg("irq masked", 32'h0000_0000, {31'h0000_0000, irq});
    wr(period_match_timer8_pkg::ADDR_ENABLE, 8'h02);
    repeat (2) @(posedge clk_sys);
    check_reg("irq unmasked", 32'h0000_0001, {31'h0000_0000, irq});
    wr(period_match_timer8_pkg::ADDR_FLAG, 8'h00);
    rd_chk("flag cleared", period_match_timer8_pkg::ADDR_FLAG, 8'h00);
    check_reg("irq cleared", 32'h0000_0000, {31'h0000_0000, irq});
    end_sim();
  end

  // Longest stretch is the divide-by-16 timing, well under this span
  initial begin
    repeat (40000) @(posedge clk_sys);
    n_errors++;
    end_sim();
  end
endmodule : period_match_timer8_tb
